// [hdl/pps_top.sv]
// Parallel port control registers with programmable strobe polarity, APB slave
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
module pps_top (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Parallel port pins
    input wire logic [31:0] data_pins_in,
    output logic [31:0] data_pins_out,
    output logic data_pins_oe,
    output logic chip_select_pin,
    output logic write_strobe_pin,
    output logic read_strobe_pin
);
    logic [31:0] control;
    logic [31:0] mode;
    logic [31:0] address;
    logic [31:0] data_out;
    logic [31:0] data_in;
    logic [31:0] address_enable;
    logic [31:0] status;

    // Alias kind from the low two bits of the word address
    function automatic logic [31:0] alias_update(input logic [31:0] old_value,
                                                 input logic [31:0] wdata,
                                                 input logic [1:0] kind,
                                                 input logic [31:0] mask);
        logic [31:0] result;
        result = old_value;
        unique case (kind)
            pps_pkg::ALIAS_WRITE: result = wdata;
            pps_pkg::ALIAS_CLEAR: result = old_value & ~wdata;
            pps_pkg::ALIAS_SET: result = old_value | wdata;
            pps_pkg::ALIAS_INVERT: result = old_value ^ wdata;
        endcase
        return result & mask;
    endfunction

    function automatic logic hit(input logic [15:0] addr, input logic [15:0] base);
        return {addr[15:4], 4'h0} == base && addr[1:0] == 2'h0;
    endfunction

    logic access;
    logic wr;
    logic [1:0] kind;
    logic mapped;
    logic hit_control;
    logic hit_mode;
    logic hit_address;
    logic hit_data_out;
    logic hit_data_in;
    logic hit_address_enable;
    logic hit_status;

    always_comb begin
        access = psel && penable;
        wr = access && pwrite;
        kind = paddr[3:2];
        hit_control = hit(paddr, pps_pkg::CONTROL_OFFSET);
        hit_mode = hit(paddr, pps_pkg::MODE_OFFSET);
        hit_address = hit(paddr, pps_pkg::ADDRESS_OFFSET);
        hit_data_out = hit(paddr, pps_pkg::DATA_OUT_OFFSET);
        hit_data_in = hit(paddr, pps_pkg::DATA_IN_OFFSET);
        hit_address_enable = hit(paddr, pps_pkg::ADDRESS_ENABLE_OFFSET);
        hit_status = hit(paddr, pps_pkg::STATUS_OFFSET);
        mapped = hit_control | hit_mode | hit_address | hit_data_out
            | hit_data_in | hit_address_enable | hit_status;
    end

    // Sequencer handshake
    logic seq_busy;
    logic seq_start;
    logic select_active;
    logic read_active;
    logic write_active;
    logic module_on;
    logic master_mode_1;

    always_comb begin
        module_on = control[pps_pkg::CONTROL_ON_BIT];
        master_mode_1 = mode[pps_pkg::MODE_FIELD_LSB +: 2] == pps_pkg::MASTER_MODE_1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control <= pps_pkg::CONTROL_RESET;
        end else if (wr && hit_control) begin
            control <= alias_update(control, pwdata, kind, pps_pkg::CONTROL_MASK);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= pps_pkg::MODE_RESET;
        end else if (wr && hit_mode) begin
            mode <= alias_update(mode, pwdata, kind, pps_pkg::MODE_MASK);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            address <= pps_pkg::ADDRESS_RESET;
        end else if (wr && hit_address) begin
            address <= alias_update(address, pwdata, kind, pps_pkg::ADDRESS_MASK);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            address_enable <= pps_pkg::ADDRESS_ENABLE_RESET;
        end else if (wr && hit_address_enable) begin
            address_enable <= alias_update(address_enable, pwdata, kind,
                pps_pkg::ADDRESS_ENABLE_MASK);
        end
    end

    // A plain write to data out starts a write cycle on the pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_out <= pps_pkg::DATA_RESET;
        end else if (wr && hit_data_out) begin
            data_out <= alias_update(data_out, pwdata, kind, pps_pkg::DATA_MASK);
        end
    end

    // Read cycle captures the data pins at the end of the strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_in <= pps_pkg::DATA_RESET;
        end else if (read_active) begin
            data_in <= data_pins_in;
        end else if (wr && hit_data_in) begin
            data_in <= alias_update(data_in, pwdata, kind, pps_pkg::DATA_MASK);
        end
    end

    // Status is a plain store, busy shows in mode bit 15 on read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= pps_pkg::STATUS_RESET;
        end else if (wr && hit_status) begin
            status <= alias_update(status, pwdata, kind, pps_pkg::STATUS_MASK);
        end
    end

    // Plain writes to data out launch a pin cycle; busy refuses a new one
    always_comb begin
        seq_start = wr && kind == pps_pkg::ALIAS_WRITE && !seq_busy
            && (hit_data_out || (!pwrite && hit_data_in));
    end

    logic read_launch;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_launch <= 1'b0;
        end else begin
            read_launch <= access && !pwrite && hit_data_in && !seq_busy
                && kind == pps_pkg::ALIAS_WRITE;
        end
    end

    pps_strobe_seq seq (
        .pclk(pclk),
        .presetn(presetn),
        .start(seq_start || read_launch),
        .write(seq_start),
        .enable(module_on),
        .select_active(select_active),
        .read_active(read_active),
        .write_active(write_active),
        .busy(seq_busy)
    );

    // APB answer: zero wait state
    logic [31:0] next_prdata;
    always_comb begin
        next_prdata = 32'h00000000;
        if (hit_control) next_prdata = control;
        if (hit_mode) next_prdata = mode | {16'h0000, seq_busy, 15'h0000};
        if (hit_address) next_prdata = address;
        if (hit_data_out) next_prdata = data_out;
        if (hit_data_in) next_prdata = data_in;
        if (hit_address_enable) next_prdata = address_enable;
        if (hit_status) next_prdata = status;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= (psel && !penable && !pwrite) ? next_prdata : 32'h00000000;
        end
    end

    // Pin side: polarity combine in master mode 1 and the others
    logic rd_pin_active;
    logic wr_pin_active;
    always_comb begin
        rd_pin_active = master_mode_1 ? (select_active && write_active) : read_active;
        wr_pin_active = master_mode_1 ? (read_active || write_active) : write_active;
    end

    pps_pin_polarity cs_pin (
        .pclk(pclk),
        .presetn(presetn),
        .active(select_active),
        .polarity(control[pps_pkg::SELECT_POLARITY_BIT]),
        .address_use(address_enable[pps_pkg::SELECT_ADDRESS_BIT]),
        .address_level(address[pps_pkg::SELECT_ADDRESS_BIT]),
        .pin(chip_select_pin)
    );

    pps_pin_polarity wr_pin (
        .pclk(pclk),
        .presetn(presetn),
        .active(wr_pin_active),
        .polarity(control[pps_pkg::WRITE_STROBE_POLARITY_BIT]),
        .address_use(1'b0),
        .address_level(1'b0),
        .pin(write_strobe_pin)
    );

    pps_pin_polarity rd_pin (
        .pclk(pclk),
        .presetn(presetn),
        .active(rd_pin_active),
        .polarity(control[pps_pkg::READ_STROBE_POLARITY_BIT]),
        .address_use(1'b0),
        .address_level(1'b0),
        .pin(read_strobe_pin)
    );

    // Data bus drive during write cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_pins_out <= 32'h00000000;
            data_pins_oe <= 1'b0;
        end else begin
            data_pins_out <= data_out;
            data_pins_oe <= select_active && !read_active && seq_busy && write_active;
        end
    end

    alias_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr && hit_control && kind == pps_pkg::ALIAS_SET
        |=> control == (($past(control) | $past(pwdata)) & pps_pkg::CONTROL_MASK))
        else $error("set alias wrong");
    alias_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr && hit_mode && kind == pps_pkg::ALIAS_CLEAR
        |=> mode == ($past(mode) & ~$past(pwdata) & pps_pkg::MODE_MASK))
        else $error("clear alias wrong");
    alias_invert_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr && hit_address && kind == pps_pkg::ALIAS_INVERT
        |=> address == (($past(address) ^ $past(pwdata)) & pps_pkg::ADDRESS_MASK))
        else $error("invert alias wrong");
    reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        control[4] == 1'b0 && control[2] == 1'b0 && mode[31:16] == 16'h0000)
        else $error("unimplemented bit set");
    select_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        !address_enable[pps_pkg::SELECT_ADDRESS_BIT] && $stable(address_enable) |=>
        chip_select_pin == ($past(control[3]) ~^ $past(select_active)))
        else $error("select pin polarity wrong");
    write_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        !master_mode_1 |=> write_strobe_pin == ($past(control[1]) ~^ $past(write_active)))
        else $error("write strobe polarity wrong");
    enable_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        master_mode_1 |=> write_strobe_pin
        == ($past(control[1]) ~^ $past(read_active || write_active)))
        else $error("enable strobe polarity wrong");
    read_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        !master_mode_1 |=> read_strobe_pin == ($past(control[0]) ~^ $past(read_active)))
        else $error("read strobe polarity wrong");
    rw_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        master_mode_1 |=> read_strobe_pin
        == ($past(control[0]) ~^ $past(select_active && write_active)))
        else $error("direction strobe polarity wrong");
endmodule

// [hdl/pps_pkg.sv]
// Package with register map, field layout and reset values of the parallel port strobe block
// Notes on behaviour
// - Select polarity bit 3 makes chip select pin active-high at 1, active-low at 0.
// - Modes 00,01,10: write polarity bit 1 sets write strobe pin polarity.
// - Mode 11: write polarity bit 1 sets enable strobe pin polarity instead.
// - Modes 00,01,10: read polarity bit 0 sets read strobe pin polarity.
// - Mode 11: read polarity bit 0 sets combined read/write strobe polarity.
// - Polarity has no effect while the pin carries an address line.
// - Aliases at +0x4, +0x8, +0xC clear, set, invert the written bits.
// - Unimplemented bits ignore writes and read as zero, control bits 4 and 2 too.
package pps_pkg;
    localparam logic [15:0] CONTROL_OFFSET = 16'h7000;
    localparam logic [15:0] MODE_OFFSET = 16'h7010;
    localparam logic [15:0] ADDRESS_OFFSET = 16'h7020;
    localparam logic [15:0] DATA_OUT_OFFSET = 16'h7030;
    localparam logic [15:0] DATA_IN_OFFSET = 16'h7040;
    localparam logic [15:0] ADDRESS_ENABLE_OFFSET = 16'h7050;
    localparam logic [15:0] STATUS_OFFSET = 16'h7060;
    localparam logic [1:0] ALIAS_WRITE = 2'h0;
    localparam logic [1:0] ALIAS_CLEAR = 2'h1;
    localparam logic [1:0] ALIAS_SET = 2'h2;
    localparam logic [1:0] ALIAS_INVERT = 2'h3;
    // Implemented bit masks
    localparam logic [31:0] CONTROL_MASK = 32'h0000FFEB;
    localparam logic [31:0] MODE_MASK = 32'h00007F1F;
    localparam logic [31:0] ADDRESS_MASK = 32'h0000FFFF;
    localparam logic [31:0] DATA_MASK = 32'hFFFFFFFF;
    localparam logic [31:0] ADDRESS_ENABLE_MASK = 32'h0000FFFF;
    localparam logic [31:0] STATUS_MASK = 32'h0F00C08F;
    localparam logic [31:0] CONTROL_RESET = 32'h00000000;
    localparam logic [31:0] MODE_RESET = 32'h00000000;
    localparam logic [31:0] ADDRESS_RESET = 32'h00000000;
    localparam logic [31:0] DATA_RESET = 32'h00000000;
    localparam logic [31:0] ADDRESS_ENABLE_RESET = 32'h00000000;
    localparam logic [31:0] STATUS_RESET = 32'h0000008F;
    // Field positions
    localparam int CONTROL_ON_BIT = 15;
    localparam int SELECT_POLARITY_BIT = 3;
    localparam int WRITE_STROBE_POLARITY_BIT = 1;
    localparam int READ_STROBE_POLARITY_BIT = 0;
    localparam int MODE_FIELD_LSB = 8;
    localparam int SELECT_ADDRESS_BIT = 14;
    localparam logic [1:0] MASTER_MODE_1 = 2'h3;
    // Strobe sequencer timing
    localparam int STROBE_CYCLES = 2;
    typedef enum logic [1:0] {
        PPS_IDLE = 2'b00,
        PPS_SETUP = 2'b01,
        PPS_STROBE = 2'b11,
        PPS_HOLD = 2'b10
    } pps_state_type;
endpackage

// [hdl/pps_pin_polarity.sv]
// Pin level former: internal active state combined with polarity
`timescale 1ns/1ps
module pps_pin_polarity (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Internal state
    input wire logic active,
    input wire logic polarity,
    input wire logic address_use,
    input wire logic address_level,
    // Pin
    output logic pin
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin <= 1'b1;
        end else if (address_use) begin
            pin <= address_level;
        end else begin
            pin <= polarity ? active : ~active;
        end
    end

    pin_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        !address_use |=> pin == ($past(polarity) ~^ $past(active)))
        else $error("pin level does not follow active and polarity");
    addr_override_a: assert property (@(posedge pclk) disable iff (!presetn)
        address_use |=> pin == $past(address_level))
        else $error("pin not carrying address level");
endmodule

// [hdl/pps_strobe_seq.sv]
// Strobe sequencer: one access cycle on the parallel port pins
`timescale 1ns/1ps
module pps_strobe_seq (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic start,
    input wire logic write,
    input wire logic enable,
    // Internal active states
    output logic select_active,
    output logic read_active,
    output logic write_active,
    output logic busy
);
    pps_pkg::pps_state_type state;
    logic [1:0] count;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= pps_pkg::PPS_IDLE;
            count <= 2'h0;
        end else begin
            unique case (state)
                pps_pkg::PPS_IDLE: begin
                    if (start && enable) begin
                        state <= pps_pkg::PPS_SETUP;
                    end
                end
                pps_pkg::PPS_SETUP: begin
                    state <= pps_pkg::PPS_STROBE;
                    count <= 2'(pps_pkg::STROBE_CYCLES - 1);
                end
                pps_pkg::PPS_STROBE: begin
                    if (count == 2'h0) begin
                        state <= pps_pkg::PPS_HOLD;
                    end else begin
                        count <= count - 2'h1;
                    end
                end
                pps_pkg::PPS_HOLD: begin
                    state <= pps_pkg::PPS_IDLE;
                end
            endcase
        end
    end

    logic dir_write;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_write <= 1'b0;
        end else if (state == pps_pkg::PPS_IDLE && start) begin
            dir_write <= write;
        end
    end

    always_comb begin
        busy = state != pps_pkg::PPS_IDLE;
        select_active = busy;
        read_active = state == pps_pkg::PPS_STROBE && !dir_write;
        write_active = state == pps_pkg::PPS_STROBE && dir_write;
    end

    strobe_length_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(read_active || write_active) |-> (read_active || write_active) [*2]
        ##1 !(read_active || write_active))
        else $error("strobe length wrong");
endmodule

// [test/pps_far_device.sv]
// Behavioural external parallel device on the pin side
`timescale 1ns/1ps
module pps_far_device (
    // Clock
    input wire logic pclk,
    // Pin levels that mean active
    input wire logic select_level,
    input wire logic write_level,
    // Pins
    input wire logic chip_select_pin,
    input wire logic write_strobe_pin,
    input wire logic [31:0] data_pins_out,
    input wire logic data_pins_oe,
    output logic [31:0] data_pins_in
);
    localparam logic [31:0] READ_WORD = 32'hC3A55A3C;
    logic [31:0] last_write = 32'h00000000;
    logic [31:0] flip = 32'h0F0F0F0F;
    // Released bus flips every cycle, so a stale value cannot pass for data
    always @(posedge pclk) begin
        flip <= ~flip;
        if (write_strobe_pin === write_level && data_pins_oe === 1'b1) begin
            last_write <= data_pins_out;
        end
    end
    // Drives only while selected and the port is not driving
    assign data_pins_in = (chip_select_pin === select_level && data_pins_oe === 1'b0) ?
                          READ_WORD : flip;
endmodule

// [test/parallel_port_strobe_polarity_test.sv]
// Self-checking bench for the parallel port control block
`timescale 1ns/1ps
module parallel_port_strobe_polarity_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] data_pins_in;
    logic [31:0] data_pins_out;
    logic data_pins_oe;
    logic chip_select_pin;
    logic write_strobe_pin;
    logic read_strobe_pin;
    logic lv_cs = 1'b0;
    logic lv_wr = 1'b0;
    int errors = 0;
    int checks_done = 0;
    always #25 pclk = ~pclk;
    pps_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .data_pins_in(data_pins_in),
        .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe),
        .chip_select_pin(chip_select_pin), .write_strobe_pin(write_strobe_pin),
        .read_strobe_pin(read_strobe_pin));
    pps_far_device far (.pclk(pclk), .select_level(lv_cs), .write_level(lv_wr),
        .chip_select_pin(chip_select_pin), .write_strobe_pin(write_strobe_pin),
        .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe),
        .data_pins_in(data_pins_in));
    task automatic stop_test();
        if (errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
            if (n > 20) begin
                errors++;
                $display("mismatch at %0t: no pready", $time);
                stop_test();
            end
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wreg(input logic [15:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rreg(input logic [15:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h00000000, r, e);
        check_word({r[31:1], r[0] ^ e}, exp);
    endtask
    // Which pins reached their active level over one access cycle
    task automatic watch(input logic a_cs, input logic a_wr, input logic a_rd,
                         output logic [31:0] s);
        s = 32'h00000000;
        repeat (10) begin
            @(posedge pclk);
            #1;
            s = s | {29'h0, chip_select_pin === a_cs, write_strobe_pin === a_wr,
                     read_strobe_pin === a_rd};
        end
    endtask
    task automatic idle_pins(input logic [31:0] exp);
        repeat (2) @(posedge pclk);
        #1;
        check_word({29'h0, chip_select_pin, write_strobe_pin, read_strobe_pin}, exp);
    endtask
    task automatic test_reset();
        logic [15:0] offs [7] = '{16'h7000, 16'h7010, 16'h7020, 16'h7030, 16'h7040,
                                  16'h7050, 16'h7060};
        idle_pins(32'h00000007);
        for (int i = 0; i < 7; i++) begin
            rreg(offs[i], (i == 6) ? 32'h0000008F : 32'h00000000);
        end
    endtask
    task automatic test_alias();
        logic [15:0] offs [3] = '{16'h7010, 16'h7020, 16'h7050};
        logic [31:0] masks [3] = '{32'h00007F1F, 32'h0000FFFF, 32'h0000FFFF};
        for (int i = 0; i < 3; i++) begin
            wreg(offs[i], 32'hFFFFFFFF);
            rreg(offs[i], masks[i]);
            wreg(offs[i], 32'h00000000);
        end
        wreg(16'h7010, 32'h00000F1F);
        wreg(16'h7014, 32'h00000300);
        rreg(16'h7010, 32'h00000C1F);
        wreg(16'h702C, 32'hFFFF00FF);
        rreg(16'h7020, 32'h000000FF);
        wreg(16'h7010, 32'h00000000);
        wreg(16'h7020, 32'h00000000);
        wreg(16'h7000, 32'hFFFFFFFF);
        rreg(16'h7000, 32'h0000FFEB);
        wreg(16'h7004, 32'h00000800);
        rreg(16'h7000, 32'h0000F7EB);
        wreg(16'h7008, 32'h00000014);
        rreg(16'h7000, 32'h0000F7EB);
        wreg(16'h700C, 32'h00000003);
        rreg(16'h7000, 32'h0000F7E8);
        wreg(16'h7000, 32'h00000000);
    endtask
    task automatic test_polarity();
        for (int i = 0; i < 8; i++) begin
            wreg(16'h7000, 32'h00008000 | {28'h0, i[2], 1'b0, i[1], i[0]});
            idle_pins(~i & 32'h00000007);
        end
    endtask
    task automatic test_cycles();
        logic [31:0] s;
        logic [31:0] r;
        logic e;
        for (int p = 0; p < 2; p++) begin
            lv_cs <= p[0];
            lv_wr <= p[0];
            wreg(16'h7000, p[0] ? 32'h0000800B : 32'h00008000);
            wreg(16'h7030, 32'h5A00F00D ^ p);
            watch(p[0], p[0], p[0], s);
            check_word(s, 32'h00000006);
            check_word(far.last_write, 32'h5A00F00D ^ p);
            check_word(data_pins_out, 32'h5A00F00D ^ p);
            apb(1'b0, 16'h7040, 32'h00000000, r, e);
            watch(p[0], p[0], p[0], s);
            check_word(s, 32'h00000005);
            rreg(16'h7040, 32'hC3A55A3C);
            watch(p[0], p[0], p[0], s);
        end
    endtask
    task automatic test_master1();
        logic [31:0] s;
        logic [31:0] r;
        logic e;
        lv_wr <= 1'b1;
        lv_cs <= 1'b0;
        wreg(16'h7010, 32'h00000300);
        wreg(16'h7000, 32'h00008002);
        idle_pins(32'h00000005);
        wreg(16'h7030, 32'h0000A5A5);
        watch(1'b0, 1'b1, 1'b0, s);
        check_word(s, 32'h00000007);
        check_word(far.last_write, 32'h0000A5A5);
        apb(1'b0, 16'h7040, 32'h00000000, r, e);
        watch(1'b0, 1'b1, 1'b0, s);
        check_word(s, 32'h00000006);
        // two quiet cycles after the module is switched off
        wreg(16'h7004, 32'h00008000);
        repeat (2) @(posedge pclk);
        wreg(16'h7010, 32'h00000000);
    endtask
    task automatic test_address_pin();
        wreg(16'h7000, 32'h00008008);
        wreg(16'h7050, 32'h00004000);
        wreg(16'h7020, 32'h00004000);
        idle_pins(32'h00000007);
        wreg(16'h7020, 32'h00000000);
        wreg(16'h700C, 32'h00000008);
        idle_pins(32'h00000003);
        wreg(16'h7050, 32'h00000000);
        idle_pins(32'h00000007);
    endtask
    task automatic test_unmapped();
        logic [31:0] r;
        logic e;
        wreg(16'h7000, 32'h00000003);
        apb(1'b1, 16'h7070, 32'hFFFFFFFF, r, e);
        check_word({31'h00000000, e}, 32'h00000001);
        apb(1'b0, 16'h7070, 32'h00000000, r, e);
        check_word({r[31:1], r[0] ^ ~e}, 32'h00000000);
        rreg(16'h7000, 32'h00000003);
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        test_reset();
        test_alias();
        test_polarity();
        test_cycles();
        test_master1();
        test_address_pin();
        test_unmapped();
        stop_test();
    end
endmodule
